// ### inc/fad_defines.svh
// register offsets, field positions and reset values of the flash converter output block
`ifndef FAD_DEFINES_SVH
`define FAD_DEFINES_SVH

`define FAD_ADDR_W          8
`define FAD_OFS_CTRL        8'h00
`define FAD_OFS_STATUS      8'h04
`define FAD_OFS_INT_STAT    8'h08
`define FAD_OFS_INT_MASK    8'h0c

`define FAD_CTRL_RUN_BIT    0
`define FAD_CTRL_RESET      1'h1
`define FAD_INT_MASK_RESET  2'h0

`define FAD_INT_NEW_BIT     0
`define FAD_INT_OVR_BIT     1
`define FAD_INT_W           2

`define FAD_STAT_OVR_BIT    6
`define FAD_STAT_SMP_BIT    7
`define FAD_STAT_OE_BIT     8
`define FAD_STAT_OVR_OE_BIT 9

`define FAD_CODE_W          6
`define FAD_COMP_W          64

`endif

// ### inc/fad_pkg.sv
// types shared by the flash converter output block
package fad_pkg;

    // one conversion result: overrange flag above the six result bits
    typedef struct packed {
        logic       ovr;
        logic [5:0] code;
    } fad_word_t;

    // register bus answer carried as one group
    typedef struct packed {
        logic        ready;
        logic        slverr;
        logic [31:0] rdata;
    } fad_apb_rsp_t;

endpackage : fad_pkg

// ### hdl/fad_encoder.sv
// thermometer to binary encoder of the comparator bank
`timescale 1ns/1ps
`include "fad_defines.svh"

module fad_encoder (
    input  wire logic [63:0]       comp_i,
    output fad_pkg::fad_word_t     word_o
);
    import fad_pkg::*;

    logic [6:0] sum [0:63];

    // -------------------------------------------------
    // ones count of the 63 code comparators
    // -------------------------------------------------
    assign sum[0] = 7'h00;
    genvar i;
    generate
        for (i = 0; i < 63; i++) begin : g_cnt
            assign sum[i+1] = sum[i] + {6'h00, comp_i[i]};
        end
    endgenerate

    // -------------------------------------------------
    // output word
    // -------------------------------------------------
    // RL7 overrange comparator
    assign word_o.ovr  = comp_i[63];
    // RL4 binary weighting
    assign word_o.code = comp_i[63] ? 6'h3f : sum[63][5:0];

endmodule : fad_encoder

// ### hdl/fad_top.sv
// flash converter digital output side: phase control, result pipeline, three-state control, apb registers
// What this block does
// RL1 - phase low: sample while converter clock low, balance while high.
// RL2 - bus drive enable low floats all result bits and overrange flag.
// RL3 - data bits enable low drives result bits; high floats them, flag stays.
// RL4 - result is six binary bits, bit 0 least significant, plus overrange.
// RL5 - result and flag are registered at the edge after encoding completes.
// RL6 - each sample's result appears one and a half clock cycles after sampling.
// RL7 - overrange set when the top sixty-fourth comparator trips.
// RL8 - outputs change only at the edge that begins the sample half cycle.
// RL9 - phase high swaps the halves: sample while clock high.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "fad_defines.svh"

module fad_top (
    input  wire logic        SYS_CLK_I,
    input  wire logic        RESET_I,
    input  wire logic        CONV_CLK_I,
    input  wire logic        PHASE_I,
    input  wire logic [63:0] COMPARATOR_I,
    input  wire logic        BUS_DRIVE_ENABLE_I,
    input  wire logic        DATA_BITS_ENABLE_N_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    output logic      [5:0]  CONV_RESULT_O,
    output logic             CONV_RESULT_OE_O,
    output logic             OVERRANGE_FLAG_O,
    output logic             OVERRANGE_FLAG_OE_O,
    output logic             IRQ_O
);
    import fad_pkg::*;

    // -------------------------------------------------
    // declarations
    // -------------------------------------------------
    logic         clk_q, phase_q, sampling_q;
    logic         sampling, sample_start, balance_start;
    logic [63:0]  cap_q;
    fad_word_t    enc_word, stage1_q, stage2_q, out_q;
    logic         oe_q, ovr_oe_q;
    logic         run_q;
    logic [1:0]   int_stat_q, int_stat_d, int_mask_q, int_set;
    logic         irq_q;
    fad_apb_rsp_t rsp_q, rsp_d;
    logic         acc, wr_en;
    logic         hit_ctrl, hit_stat, hit_int, hit_mask, hit_any;
    logic [31:0]  rd_mux;

    // -------------------------------------------------
    // phase control
    // -------------------------------------------------
    // RL1 RL9 half cycle selection
    assign sampling      = ~(clk_q ^ phase_q);
    assign sample_start  = sampling & ~sampling_q;
    assign balance_start = ~sampling & sampling_q;

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            clk_q      <= 1'b0;
            phase_q    <= 1'b0;
            // idle pins read as sampling, so no false sample start after reset
            sampling_q <= 1'b1;
        end else begin
            clk_q      <= CONV_CLK_I;
            phase_q    <= PHASE_I;
            sampling_q <= sampling;
        end
    end

    // -------------------------------------------------
    // conversion pipeline
    // -------------------------------------------------
    fad_encoder u_enc (
        .comp_i (cap_q),
        .word_o (enc_word)
    );

    // RL6 capture, two encode stages, output: three half cycles
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            cap_q    <= 64'h0;
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            if (balance_start && run_q)
                cap_q <= COMPARATOR_I;
            if (sample_start)
                stage1_q <= enc_word;
            if (balance_start)
                stage2_q <= stage1_q;
        end
    end

    // RL5 RL8 output flip-flops load at sample start only
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I)
            out_q <= '0;
        else if (sample_start)
            out_q <= stage2_q;
    end

    // RL4 bit 0 is the least significant result bit
    assign CONV_RESULT_O    = out_q.code;
    assign OVERRANGE_FLAG_O = out_q.ovr;

    // -------------------------------------------------
    // three-state control
    // -------------------------------------------------
    // RL2 RL3 chip enable truth table
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            oe_q     <= 1'b0;
            ovr_oe_q <= 1'b0;
        end else begin
            oe_q     <= BUS_DRIVE_ENABLE_I & ~DATA_BITS_ENABLE_N_I;
            ovr_oe_q <= BUS_DRIVE_ENABLE_I;
        end
    end
    assign CONV_RESULT_OE_O    = oe_q;
    assign OVERRANGE_FLAG_OE_O = ovr_oe_q;

    // -------------------------------------------------
    // apb slave
    // -------------------------------------------------
    assign acc      = PSEL_I & PENABLE_I;
    assign wr_en    = acc & rsp_q.ready & PWRITE_I & ~rsp_q.slverr;
    assign hit_ctrl = PADDR_I == `FAD_OFS_CTRL;
    assign hit_stat = PADDR_I == `FAD_OFS_STATUS;
    assign hit_int  = PADDR_I == `FAD_OFS_INT_STAT;
    assign hit_mask = PADDR_I == `FAD_OFS_INT_MASK;
    assign hit_any  = hit_ctrl | hit_stat | hit_int | hit_mask;

    assign rd_mux = hit_ctrl ? {31'h0, run_q} :
                    hit_stat ? {22'h0, ovr_oe_q, oe_q, sampling, out_q} :
                    hit_int  ? {30'h0, int_stat_q} :
                    hit_mask ? {30'h0, int_mask_q} : 32'h0;

    // one wait state: answer in the second access cycle
    assign rsp_d.ready  = acc & ~rsp_q.ready;
    assign rsp_d.slverr = acc & ~rsp_q.ready & ~hit_any;
    assign rsp_d.rdata  = (acc & ~rsp_q.ready & ~PWRITE_I) ? rd_mux : 32'h0;

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I)
            rsp_q <= '0;
        else
            rsp_q <= rsp_d;
    end
    assign PREADY_O  = rsp_q.ready;
    assign PSLVERR_O = rsp_q.slverr;
    assign PRDATA_O  = rsp_q.rdata;

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            run_q      <= `FAD_CTRL_RESET;
            int_mask_q <= `FAD_INT_MASK_RESET;
        end else begin
            if (wr_en && hit_ctrl)
                run_q <= PWDATA_I[`FAD_CTRL_RUN_BIT];
            if (wr_en && hit_mask)
                int_mask_q <= PWDATA_I[1:0];
        end
    end

    // -------------------------------------------------
    // interrupts
    // -------------------------------------------------
    assign int_set[`FAD_INT_NEW_BIT] = sample_start;
    assign int_set[`FAD_INT_OVR_BIT] = sample_start & stage2_q.ovr;
    // set wins over a write-one clear in the same cycle
    assign int_stat_d = int_set | (int_stat_q & ~((wr_en && hit_int) ? PWDATA_I[1:0] : 2'h0));

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            int_stat_q <= 2'h0;
            irq_q      <= 1'b0;
        end else begin
            int_stat_q <= int_stat_d;
            irq_q      <= |(int_stat_d & int_mask_q);
        end
    end
    assign IRQ_O = irq_q;

    // -------------------------------------------------
    // assertions
    // -------------------------------------------------
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);

    // reference pipeline: the word each capture should give, one balance start after the capture
    fad_word_t ref_a_q, ref_b_q, ref_word;
    assign ref_word.ovr  = COMPARATOR_I[63];
    assign ref_word.code = COMPARATOR_I[63] ? 6'h3f : 6'($countones(COMPARATOR_I[62:0]));
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            ref_a_q <= '0;
            ref_b_q <= '0;
        end else if (balance_start) begin
            if (run_q)
                ref_a_q <= ref_word;
            ref_b_q <= ref_a_q;
        end
    end

    sequence s_capture;
        balance_start ##1 !balance_start;
    endsequence
    sequence s_release;
        sample_start;
    endsequence

    a_phase_low_map: assert property (!PHASE_I |=> sampling != $past(CONV_CLK_I)) // RL1
        else $error("phase low half cycle mapping wrong");
    a_phase_high_map: assert property (PHASE_I |=> sampling == $past(CONV_CLK_I)) // RL9
        else $error("phase high half cycle mapping wrong");
    a_bus_float: assert property (!BUS_DRIVE_ENABLE_I |=> !CONV_RESULT_OE_O && !OVERRANGE_FLAG_OE_O) // RL2
        else $error("outputs driven with bus drive enable low");
    a_bits_float: assert property (BUS_DRIVE_ENABLE_I && DATA_BITS_ENABLE_N_I
                                   |=> !CONV_RESULT_OE_O && OVERRANGE_FLAG_OE_O) // RL3
        else $error("data bits enable high mishandled");
    a_bits_drive: assert property (BUS_DRIVE_ENABLE_I && !DATA_BITS_ENABLE_N_I
                                   |=> CONV_RESULT_OE_O && OVERRANGE_FLAG_OE_O) // RL3
        else $error("data bits not driven");
    a_result_load: assert property (s_release |=> CONV_RESULT_O == $past(stage2_q.code)) // RL4
        else $error("result word not loaded at sample start");
    a_out_stable: assert property (!sample_start |=> $stable(CONV_RESULT_O) && $stable(OVERRANGE_FLAG_O)) // RL8
        else $error("output changed outside sample start");
    a_ovr_encode: assert property (s_capture |-> (enc_word.ovr == cap_q[63])
                                   && (!cap_q[63] || enc_word.code == 6'h3f)) // RL7
        else $error("overrange encoding wrong");
    a_latency_path: assert property (s_release |=> OVERRANGE_FLAG_O == $past(stage2_q.ovr)) // RL5
        else $error("overrange not loaded with result");
    a_latency_word: assert property (s_release |=> {OVERRANGE_FLAG_O, CONV_RESULT_O} == $past(ref_b_q)) // RL6
        else $error("result latency not three half cycles");

endmodule : fad_top

// ### bench/fad_host_bus.sv
// host side bus model: resolves the three-state result lines seen by the reader
`timescale 1ns/1ps
module fad_host_bus (
    input  wire logic [5:0] res_i,
    input  wire logic       res_oe_i,
    input  wire logic       ovr_i,
    input  wire logic       ovr_oe_i,
    output logic      [5:0] bus_res_o,
    output logic            bus_ovr_o
);
    // released lines float up through the bus pull-ups
    assign bus_res_o = res_oe_i ? res_i : 6'h3f;
    assign bus_ovr_o = ovr_oe_i ? ovr_i : 1'b1;
endmodule : fad_host_bus

// ### bench/tb_flash_adc_output_interface.sv
// self-checking bench of the flash converter output block
`timescale 1ns/1ps
module tb_flash_adc_output_interface;
    logic clk = 0, rst = 1, cclk = 0, ph = 0, be = 1, de_n = 0;
    logic psel = 0, pen = 0, pwr = 0;
    logic [7:0] paddr = 0, lf = 8'h57;
    logic [31:0] pwd = 0, prd;
    logic [63:0] comp = 0;
    logic [5:0] res, bres;
    logic rdy, err, roe, ovr, foe, bovr, irq;
    logic [6:0] rq[$], last_out, w;
    logic [33:0] aq[$], ae;
    int error_cnt = 0, n_checks = 0;
    event res_evt;
    always #12.5 clk = ~clk;
    fad_top dut_u (.SYS_CLK_I(clk), .RESET_I(rst), .CONV_CLK_I(cclk), .PHASE_I(ph), .COMPARATOR_I(comp),
        .BUS_DRIVE_ENABLE_I(be), .DATA_BITS_ENABLE_N_I(de_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err),
        .CONV_RESULT_O(res), .CONV_RESULT_OE_O(roe), .OVERRANGE_FLAG_O(ovr), .OVERRANGE_FLAG_OE_O(foe),
        .IRQ_O(irq));
    fad_host_bus host_u (.res_i(res), .res_oe_i(roe), .ovr_i(ovr), .ovr_oe_i(foe), .bus_res_o(bres),
        .bus_ovr_o(bovr));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        aq.push_back({wr, e});
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= wr; paddr <= a; pwd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (rdy !== 1'b1);
        psel <= 0; pen <= 0;
    endtask : apb
    task automatic run(input logic p);
        rq.delete();
        @(posedge clk);
        ph <= p; cclk <= !p;
        repeat (6) @(posedge clk);
        for (int j = 0; j < 10; j++) begin
            lf = lfsr(lf);
            w = (j == 2 || (lf[7] & lf[0])) ? 7'h7f : (j == 1 ? 7'h3f : (j == 0 ? 7'h00 : {1'b0, lf[5:0]}));
            @(posedge clk);
            cclk <= p;
            comp <= w[6] ? '1 : {1'b0, (63'h1 << w[5:0]) - 63'h1};
            rq.push_back(w);
            repeat (3) @(posedge clk);
            if (rq.size() == 3) ->res_evt;
            @(posedge clk);
            cclk <= !p;
            repeat (3) @(posedge clk);
        end
        $display("test conversion phase %0d done", p);
    endtask : run
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    // ----------------------------------------
    // output watchers
    // ----------------------------------------
    always @(posedge clk) begin
        if (rdy === 1'b1) begin
            ae = aq.pop_front();
            check({31'h0, err}, {31'h0, ae[32]});
            if (!ae[33]) check(prd, ae[31:0]);
        end
    end
    always @(res_evt) begin
        last_out = rq.pop_front();
        check({25'h0, bovr, bres}, {25'h0, last_out});
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        apb(0, 8'h00, 0, 33'h1);
        apb(0, 8'h0c, 0, 33'h0);
        apb(1, 8'h10, 32'hff, 33'h1_0000_0000);
        apb(0, 8'h10, 0, 33'h1_0000_0000);
        $display("test register map done");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            {be, de_n} <= 2'(k);
            repeat (3) @(posedge clk);
            check({30'h0, roe, foe}, {30'h0, k == 2, k[1]});
            // released lines read as pull-up level, driven ones as the cleared result
            check({25'h0, bovr, bres}, {25'h0, !k[1], k == 2 ? 6'h00 : 6'h3f});
        end
        @(posedge clk);
        {be, de_n} <= 2'b10;
        $display("test enables done");
        run(0);
        apb(0, 8'h04, 0, {23'h0, 3'b110, last_out});
        run(1);
        apb(0, 8'h08, 0, 33'h3);
        check({31'h0, irq}, 32'h0);
        apb(1, 8'h0c, 32'h3, 33'h0);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        apb(1, 8'h08, 32'h1, 33'h0);
        apb(0, 8'h08, 0, 33'h2);
        apb(1, 8'h08, 32'h2, 33'h0);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        $display("test interrupts done");
        apb(1, 8'h00, 0, 33'h0);
        apb(0, 8'h00, 0, 33'h0);
        $display("test run control done");
        summarize();
    end
    initial begin
        #(25 * 20000);
        error_cnt++;
        summarize();
    end
endmodule : tb_flash_adc_output_interface
